//--- rtl/lpc_defs.vh
// Constants for the link procedure control block: PDU kinds, address kinds, modes.
// Assumes the PDU parser below has already decoded frames into these codes.
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH
// PDU kind codes (4 bits)
`define LPC_K_UI 4'h0
`define LPC_K_URR 4'h1
`define LPC_K_URNR 4'h2
`define LPC_K_TEST 4'h3
`define LPC_K_DISC 4'h4
`define LPC_K_UA 4'h5
`define LPC_K_DM 4'h6
`define LPC_K_I 4'h7
`define LPC_K_S 4'h8
`define LPC_K_SABME 4'h9
// Address kind codes (2 bits)
`define LPC_A_INDIV 2'h0
`define LPC_A_GROUP 2'h1
`define LPC_A_SPECIAL 2'h2
`define LPC_A_GLOBAL 2'h3
// Link modes
`define LPC_M_ADM 1'b0
`define LPC_M_ABM 1'b1
// Field positions of the source address octet
`define LPC_CR_BIT 7
// Reset values
`define LPC_BUSY_RST 1'b0
`define LPC_MODE_RST 1'b0
`endif

//--- rtl/lpc_busy_mem.v
// Per-peer busy table: one bit per peer address, registered read data.
// Assumes a single clock; write and read may occur in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_busy_mem #(
  parameter AW = 7
) (
  input wire clk, // System clock
  input wire rstn, // Synchronous reset, active low
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Peer written
  input wire wr_data, // Busy value
  input wire [AW-1:0] rd_addr, // Peer looked up
  output reg rd_data_ff // Busy of looked-up peer
);
  reg [(1<<AW)-1:0] busy_ff;
  ////////////////////////////////////////////////////////////////////////
  // Flat bit vector so reset can clear every peer at once
  always @(posedge clk) begin
    if (!rstn) begin
      busy_ff <= {(1<<AW){`LPC_BUSY_RST}};
      rd_data_ff <= `LPC_BUSY_RST;
    end else begin
      if (wr_en)
        busy_ff[wr_addr] <= wr_data;
      // Write-through so a gate decision never sees stale busy
      rd_data_ff <= (wr_en && wr_addr == rd_addr) ? wr_data : busy_ff[rd_addr];
    end
  end
endmodule // lpc_busy_mem
`default_nettype wire

//--- rtl/lpc_rx_class.v
// Receive classifier: splits a decoded PDU header into command/response and validity.
// Assumes header fields arrive in parallel with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_rx_class (
  input wire clk, // System clock
  input wire rstn, // Synchronous reset, active low
  input wire in_vld, // Header valid pulse
  input wire [7:0] in_src, // Source address octet
  input wire [1:0] in_src_kind, // Source address kind
  input wire [1:0] in_dst_kind, // Destination address kind
  input wire in_fcs_err, // Frame check failed
  output reg out_vld_ff, // Classified pulse
  output reg out_cmd_ff, // 1 command, 0 response
  output reg out_ok_ff // Header acceptable
);
  ////////////////////////////////////////////////////////////////////////
  // Leading source bit marks command/response; bad source kinds rejected
  always @(posedge clk) begin
    if (!rstn) begin
      out_vld_ff <= 1'b0;
      out_cmd_ff <= 1'b0;
      out_ok_ff <= 1'b0;
    end else begin
      out_vld_ff <= in_vld;
      out_cmd_ff <= ~in_src[`LPC_CR_BIT];
      // Any destination kind accepted; source must be individual or special
      out_ok_ff <= !in_fcs_err && (in_src_kind == `LPC_A_INDIV || in_src_kind == `LPC_A_SPECIAL);
    end
  end
endmodule // lpc_rx_class
`default_nettype wire

//--- rtl/lpc_station.v
// Link procedure control for one station: Type 1 connectionless traffic and
// Type 2 balanced/disconnected mode handling, on decoded PDU headers.
// Assumes a parser below hands decoded headers and a framer takes transmit requests.
// Limitation: one response slot; a reply raised while another is pending
// replaces it, and one raised while another is in flight is lost.
//
// Behaviour
// - One merged busy record per peer, shared by Type 1 and Type 3 traffic.
// - Every Type 1 procedure is always supported while operational.
// - Leading source address bit marks command versus response.
// - Command destinations may be individual, group, special or global.
// - Source address must be individual or special.
// - Poll bit transmitted as zero for all Type 1 traffic.
// - User data to a peer goes out as UI commands.
// - No UI commands to a peer after URNR until it clears.
// - UI command with poll zero is never acknowledged.
// - Errored TEST commands are dropped with no response.
// - TEST failure follow-up belongs to the initiator; responder does nothing. Here an errored received TEST still pulses test_evt_ff.
// - Type 2 operational mode is asynchronous balanced mode.
// - Balanced mode may send commands and responses without peer permission.
// - Balanced-mode transmissions carry information and status change PDUs.
// - DISC in balanced mode answered with UA when executable.
// - Type 2 non-operational mode is asynchronous disconnected mode.
// - Disconnected mode sends and accepts no user data.
// - Disconnect conditions are fixed configuration, not run-time decisions.
// - Disconnected mode answers DISC, I or S with DM.
// - Disconnected mode never enters frame-reject condition.
// - Busy URNR reply to UI has final bit 1, to UI source.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_station #(
  parameter AW = 7, // Peer address width
  parameter DISC_OK = 1'b1, // Station can execute DISC
  parameter ADM_ON_SABME_ONLY = 1'b1 // Fixed rule: only SABME leaves ADM
) (
  input wire clk, // System clock, 40 MHz
  input wire rstn, // Synchronous reset, active low
  input wire rx_vld, // Decoded PDU header pulse
  input wire [3:0] rx_kind, // PDU kind code
  input wire [7:0] rx_src, // Source address octet
  input wire [1:0] rx_src_kind, // Source address kind
  input wire [1:0] rx_dst_kind, // Destination address kind
  input wire rx_pf, // Received poll/final bit
  input wire rx_err, // Frame in error
  input wire rx_local_busy, // Local receiver cannot take UI
  input wire force_adm, // Configured disconnect condition
  input wire test_fail, // Own TEST timed out or mismatched
  input wire usr_req, // Host wants to send user data
  input wire [AW-1:0] usr_dst, // Destination peer
  input wire usr_t2, // Request is Type 2 I data
  input wire tx_rdy, // Framer accepts request
  output reg usr_ack_ff, // User request taken pulse
  output reg usr_blk_ff, // User request refused pulse
  output reg tx_vld_ff, // Transmit request
  output reg [3:0] tx_kind_ff, // Kind to send
  output reg [AW-1:0] tx_dst_ff, // Destination peer
  output reg tx_cmd_ff, // 1 command, 0 response
  output reg tx_pf_ff, // Poll/final bit to send
  output reg rx_data_ff, // User data accepted pulse
  output reg test_evt_ff, // TEST problem event pulse
  output reg mode_ff // Current Type 2 mode
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CHK = 2'h1;
  localparam ST_SEND = 2'h2;

  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [3:0] kind_ff;
  reg [AW-1:0] src_ff;
  reg pf_ff;
  reg err_ff;
  reg [AW-1:0] dst_ff;
  reg t2_ff;
  reg pend_rsp_ff;
  reg [3:0] rsp_kind_ff;
  reg [AW-1:0] rsp_dst_ff;
  reg rsp_pf_ff;
  wire cls_vld;
  wire cls_cmd;
  wire cls_ok;
  wire peer_busy;
  wire bm_wr;
  wire bm_val;
  wire usr_refused;
  wire rsp_first;

  // True when the kind is a Type 2 data or supervisory PDU
  function is_i_or_s;
    input [3:0] k;
    begin
      is_i_or_s = (k == `LPC_K_I) || (k == `LPC_K_S);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Receive classification
  lpc_rx_class u_cls (
    .clk(clk),
    .rstn(rstn),
    .in_vld(rx_vld),
    .in_src(rx_src),
    .in_src_kind(rx_src_kind),
    .in_dst_kind(rx_dst_kind),
    .in_fcs_err(rx_err),
    .out_vld_ff(cls_vld),
    .out_cmd_ff(cls_cmd),
    .out_ok_ff(cls_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // Header held one cycle to line up with the classifier
  always @(posedge clk) begin
    if (!rstn) begin
      kind_ff <= 4'h0;
      src_ff <= {AW{1'b0}};
      pf_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (rx_vld) begin
      kind_ff <= rx_kind;
      src_ff <= rx_src[AW-1:0];
      pf_ff <= rx_pf;
      err_ff <= rx_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One busy table serves Type 1 and Type 3 alike, so no per-type copies
  assign bm_wr = cls_vld && cls_ok && (kind_ff == `LPC_K_URNR || kind_ff == `LPC_K_URR);
  assign bm_val = (kind_ff == `LPC_K_URNR);

  lpc_busy_mem #(.AW(AW)) u_busy (
    .clk(clk),
    .rstn(rstn),
    .wr_en(bm_wr),
    .wr_addr(src_ff),
    .wr_data(bm_val),
    .rd_addr(dst_ff),
    .rd_data_ff(peer_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode: configured condition forces ADM; SABME is the only way out
  always @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= `LPC_MODE_RST;
    end else if (force_adm) begin
      mode_ff <= `LPC_M_ADM;
    end else if (cls_vld && cls_ok && cls_cmd) begin
      if (kind_ff == `LPC_K_SABME && ADM_ON_SABME_ONLY)
        mode_ff <= `LPC_M_ABM;
      // DISC leaves ABM only when the station can carry it out
      else if (kind_ff == `LPC_K_DISC && mode_ff == `LPC_M_ABM && DISC_OK)
        mode_ff <= `LPC_M_ADM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive responses; a pending reply is never dropped by a user send
  always @(posedge clk) begin
    if (!rstn) begin
      pend_rsp_ff <= 1'b0;
      rsp_kind_ff <= 4'h0;
      rsp_dst_ff <= {AW{1'b0}};
      rsp_pf_ff <= 1'b0;
      rx_data_ff <= 1'b0;
      test_evt_ff <= 1'b0;
    end else begin
      rx_data_ff <= 1'b0;
      test_evt_ff <= test_fail;
      // Cleared only when the framer takes the response itself, so a
      // reply raised during a user send is not lost
      if (tx_vld_ff && tx_rdy && !tx_cmd_ff)
        pend_rsp_ff <= 1'b0;
      if (cls_vld) begin
        // Errored TEST either way is reported; a bad-source TEST command is reported too
        if (kind_ff == `LPC_K_TEST && (err_ff || (cls_cmd && !cls_ok))) begin
          test_evt_ff <= 1'b1;
        end else if (cls_ok && cls_cmd) begin
          case (kind_ff)
            `LPC_K_UI: begin
              if (rx_local_busy) begin
                pend_rsp_ff <= 1'b1;
                rsp_kind_ff <= `LPC_K_URNR;
                rsp_dst_ff <= src_ff;
                rsp_pf_ff <= 1'b1;
              end else begin
                rx_data_ff <= 1'b1; // no acknowledgement for P=0
              end
            end
            `LPC_K_TEST: begin
              if (pf_ff) begin
                pend_rsp_ff <= 1'b1;
                rsp_kind_ff <= `LPC_K_TEST;
                rsp_dst_ff <= src_ff;
                rsp_pf_ff <= 1'b1;
              end
            end
            `LPC_K_DISC: begin
              pend_rsp_ff <= 1'b1;
              rsp_dst_ff <= src_ff;
              rsp_pf_ff <= pf_ff;
              rsp_kind_ff <= (mode_ff == `LPC_M_ABM && DISC_OK) ? `LPC_K_UA : `LPC_K_DM;
            end
            `LPC_K_SABME: begin
              pend_rsp_ff <= 1'b1;
              rsp_dst_ff <= src_ff;
              rsp_pf_ff <= pf_ff;
              rsp_kind_ff <= `LPC_K_UA;
            end
            default: begin
              if (is_i_or_s(kind_ff)) begin
                if (mode_ff == `LPC_M_ADM) begin
                  pend_rsp_ff <= 1'b1; // DM, never frame reject
                  rsp_kind_ff <= `LPC_K_DM;
                  rsp_dst_ff <= src_ff;
                  rsp_pf_ff <= pf_ff;
                end else if (kind_ff == `LPC_K_I) begin
                  rx_data_ff <= 1'b1; // data only accepted in ABM
                end
              end
            end
          endcase
        end else if (cls_ok && is_i_or_s(kind_ff) && mode_ff == `LPC_M_ADM) begin
          // Responses of these kinds also draw DM while detached
          pend_rsp_ff <= 1'b1;
          rsp_kind_ff <= `LPC_K_DM;
          rsp_dst_ff <= src_ff;
          rsp_pf_ff <= pf_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Send decisions shared by the sequencer and the output stage
  assign rsp_first = pend_rsp_ff && !t2_ff;
  assign usr_refused = t2_ff ? (mode_ff == `LPC_M_ADM) : peer_busy;

  ////////////////////////////////////////////////////////////////////////
  // Transmit sequencer; responses go out without waiting on the peer
  // SEND is left only once the request is taken or refused, so tx_* hold
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (pend_rsp_ff || usr_req) nxt_st = pend_rsp_ff ? ST_SEND : ST_CHK;
      ST_CHK: nxt_st = ST_SEND;
      ST_SEND: if (tx_vld_ff ? tx_rdy : (!rsp_first && usr_refused)) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit request outputs
  always @(posedge clk) begin
    if (!rstn) begin
      st_ff <= ST_IDLE;
      dst_ff <= {AW{1'b0}};
      t2_ff <= 1'b0;
      tx_vld_ff <= 1'b0;
      tx_kind_ff <= 4'h0;
      tx_dst_ff <= {AW{1'b0}};
      tx_cmd_ff <= 1'b0;
      tx_pf_ff <= 1'b0;
      usr_ack_ff <= 1'b0;
      usr_blk_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      usr_ack_ff <= 1'b0;
      usr_blk_ff <= 1'b0;
      if (st_ff == ST_IDLE && !pend_rsp_ff && usr_req) begin
        dst_ff <= usr_dst;
        t2_ff <= usr_t2;
      end
      if (st_ff == ST_IDLE && pend_rsp_ff)
        t2_ff <= 1'b0;
      if (st_ff == ST_SEND && !tx_vld_ff) begin
        if (rsp_first) begin
          tx_vld_ff <= 1'b1;
          tx_kind_ff <= rsp_kind_ff;
          tx_dst_ff <= rsp_dst_ff;
          tx_cmd_ff <= 1'b0;
          tx_pf_ff <= rsp_pf_ff;
        end else if (usr_refused) begin
          usr_blk_ff <= 1'b1;
        end else begin
          tx_vld_ff <= 1'b1;
          tx_kind_ff <= t2_ff ? `LPC_K_I : `LPC_K_UI;
          tx_dst_ff <= dst_ff;
          tx_cmd_ff <= 1'b1;
          tx_pf_ff <= 1'b0;
        end
      end
      if (tx_vld_ff && tx_rdy) begin
        tx_vld_ff <= 1'b0;
        usr_ack_ff <= tx_cmd_ff;
      end
    end
  end
endmodule // lpc_station
`default_nettype wire

//--- tb/lpc_station_asserts.sv
// Checker on the station's ports, bound below.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_station_chk #(parameter AW = 7) (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic rx_vld, // Header pulse
  input wire logic [3:0] rx_kind, // Kind
  input wire logic [7:0] rx_src, // Source octet
  input wire logic [1:0] rx_src_kind, // Source kind
  input wire logic rx_pf, // Poll bit
  input wire logic rx_err, // Frame error
  input wire logic rx_local_busy, // Local busy
  input wire logic force_adm, // Preset disconnect
  input wire logic usr_req, // User request
  input wire logic tx_rdy, // Framer ready
  input wire logic usr_ack_ff, // Request taken
  input wire logic tx_vld_ff, // Tx request
  input wire logic [3:0] tx_kind_ff, // Tx kind
  input wire logic tx_cmd_ff, // Tx command
  input wire logic tx_pf_ff, // Tx poll/final
  input wire logic rx_data_ff, // Data accepted
  input wire logic test_evt_ff, // TEST event
  input wire logic mode_ff // Mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Clean command header from an individual source
  wire good = rx_vld && !rx_err && !rx_src[7] && (rx_src_kind == `LPC_A_INDIV);
  property p_ui_pf; tx_vld_ff && tx_kind_ff == `LPC_K_UI |-> tx_cmd_ff && !tx_pf_ff; endproperty
  a_ui_pf: assert property (p_ui_pf) else $error("UI not a command with poll 0");
  property p_urnr_f; tx_vld_ff && tx_kind_ff == `LPC_K_URNR && !tx_cmd_ff |-> tx_pf_ff; endproperty
  a_urnr_f: assert property (p_urnr_f) else $error("busy reply without final 1");
  property p_hold; tx_vld_ff && !tx_rdy |=> tx_vld_ff && $stable(tx_kind_ff); endproperty
  a_hold: assert property (p_hold) else $error("tx request dropped early");
  property p_ui_quiet;
    good && rx_kind == `LPC_K_UI && !rx_pf && !rx_local_busy && !tx_vld_ff && !usr_req
      ##1 (!usr_req) [*4] |=> !tx_vld_ff;
  endproperty
  a_ui_quiet: assert property (p_ui_quiet) else $error("UI acknowledged");
  property p_test_err; rx_vld && rx_kind == `LPC_K_TEST && rx_err |-> ##2 test_evt_ff; endproperty
  a_test_err: assert property (p_test_err) else $error("errored TEST not reported");
  property p_adm_dm;
    good && mode_ff == `LPC_M_ADM && (rx_kind == `LPC_K_DISC || rx_kind == `LPC_K_I || rx_kind == `LPC_K_S)
      |-> ##[2:30] tx_vld_ff && tx_kind_ff == `LPC_K_DM && !tx_cmd_ff;
  endproperty
  a_adm_dm: assert property (p_adm_dm) else $error("no DM in disconnected mode");
  property p_abm_ua; good && mode_ff == `LPC_M_ABM && rx_kind == `LPC_K_DISC |-> ##[2:30] tx_vld_ff && tx_kind_ff == `LPC_K_UA; endproperty
  a_abm_ua: assert property (p_abm_ua) else $error("no UA to DISC");
  property p_adm_nodata; rx_vld && mode_ff == `LPC_M_ADM && rx_kind == `LPC_K_I |-> ##2 !rx_data_ff; endproperty
  a_adm_nodata: assert property (p_adm_nodata) else $error("data accepted while disconnected");
  property p_force; force_adm [*4] |-> mode_ff == `LPC_M_ADM; endproperty
  a_force: assert property (p_force) else $error("preset disconnect ignored");
  property p_ack_pulse; usr_ack_ff |=> !usr_ack_ff; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  // Main traffic seen
  c_dm: cover property (tx_vld_ff && tx_kind_ff == `LPC_K_DM);
  c_ua: cover property (tx_vld_ff && tx_kind_ff == `LPC_K_UA);
  c_urnr: cover property (tx_vld_ff && tx_kind_ff == `LPC_K_URNR);
endmodule // lpc_station_chk
bind lpc_station lpc_station_chk #(.AW(AW)) chk_u (.clk(clk), .rstn(rstn), .rx_vld(rx_vld), .rx_kind(rx_kind),
  .rx_src(rx_src), .rx_src_kind(rx_src_kind), .rx_pf(rx_pf), .rx_err(rx_err), .rx_local_busy(rx_local_busy),
  .force_adm(force_adm), .usr_req(usr_req), .tx_rdy(tx_rdy), .usr_ack_ff(usr_ack_ff), .tx_vld_ff(tx_vld_ff),
  .tx_kind_ff(tx_kind_ff), .tx_cmd_ff(tx_cmd_ff), .tx_pf_ff(tx_pf_ff), .rx_data_ff(rx_data_ff),
  .test_evt_ff(test_evt_ff), .mode_ff(mode_ff));
`default_nettype wire

//--- tb/lpc_framer_model.sv
// Framer model: takes transmit requests after a set stall.
// Assumes the station holds its request until ready.
`timescale 1ns/1ps
`default_nettype none
module lpc_framer_model (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic tx_vld, // Request
  input wire logic [3:0] dly, // Stall cycles
  output logic tx_rdy // Accept
);
  logic [3:0] wait_ff;
  // Stall counter, restarts per request
  always @(posedge clk) begin
    if (!rstn)
      wait_ff <= 4'h0;
    else if (tx_vld && !tx_rdy)
      wait_ff <= wait_ff + 4'h1;
    else
      wait_ff <= 4'h0;
  end
  // Accepts once the stall has run out, no permission round trip
  assign tx_rdy = tx_vld && (wait_ff >= dly);
endmodule // lpc_framer_model
`default_nettype wire

//--- tb/link_procedure_control_test.sv
// Self-checking bench for the station.
// Assumes the framer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module link_procedure_control_test;
  logic clk = 1'b0, rstn = 1'b0, rx_vld = 1'b0, rx_pf = 1'b0, rx_err = 1'b0, rx_local_busy = 1'b0;
  logic force_adm = 1'b0, test_fail = 1'b0, usr_req = 1'b0, usr_t2 = 1'b0;
  logic [3:0] rx_kind = 4'h0, dly = 4'h0, l_kind;
  logic [7:0] rx_src = 8'h00;
  logic [1:0] rx_src_kind = 2'h0, rx_dst_kind = 2'h0;
  logic [6:0] usr_dst = 7'h00, l_dst;
  logic l_cmd, l_pf;
  wire tx_rdy, usr_ack_ff, usr_blk_ff, tx_vld_ff, tx_cmd_ff, tx_pf_ff, rx_data_ff, test_evt_ff, mode_ff;
  wire [3:0] tx_kind_ff;
  wire [6:0] tx_dst_ff;
  integer num_errors = 0, check_count = 0, cyc = 0, tx_cnt = 0, evt_cnt = 0, dat_cnt = 0, n0 = 0;
  always #12.5 clk = ~clk;
  lpc_station dut_u (.clk(clk), .rstn(rstn), .rx_vld(rx_vld), .rx_kind(rx_kind), .rx_src(rx_src),
    .rx_src_kind(rx_src_kind), .rx_dst_kind(rx_dst_kind), .rx_pf(rx_pf), .rx_err(rx_err),
    .rx_local_busy(rx_local_busy),
    .force_adm(force_adm), .test_fail(test_fail), .usr_req(usr_req), .usr_dst(usr_dst), .usr_t2(usr_t2),
    .tx_rdy(tx_rdy), .usr_ack_ff(usr_ack_ff), .usr_blk_ff(usr_blk_ff), .tx_vld_ff(tx_vld_ff),
    .tx_kind_ff(tx_kind_ff), .tx_dst_ff(tx_dst_ff), .tx_cmd_ff(tx_cmd_ff), .tx_pf_ff(tx_pf_ff),
    .rx_data_ff(rx_data_ff), .test_evt_ff(test_evt_ff), .mode_ff(mode_ff));
  lpc_framer_model fr_u (.clk(clk), .rstn(rstn), .tx_vld(tx_vld_ff), .dly(dly), .tx_rdy(tx_rdy));
  ////////////////////////////////////////////////////////////////
  // Record each accepted transmit and count event pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    evt_cnt <= evt_cnt + test_evt_ff;
    dat_cnt <= dat_cnt + rx_data_ff;
    if (tx_vld_ff && tx_rdy) begin
      tx_cnt <= tx_cnt + 1;
      {l_kind, l_dst, l_cmd, l_pf} <= {tx_kind_ff, tx_dst_ff, tx_cmd_ff, tx_pf_ff};
    end
  end
  // Hang guard, far above the whole run
  always @(negedge clk) if (cyc == 5000) begin
    num_errors = num_errors + 1;
    final_report;
  end
  task chk(input [8*5:1] nm, input [7:0] s, input [7:0] e);
    check_count = check_count + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("mismatch %0s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task rx(input [3:0] k, input [7:0] s, input pf);
    n0 = tx_cnt;
    {rx_kind, rx_src, rx_pf, rx_vld} = {k, s, pf, 1'b1};
    @(negedge clk);
    rx_vld = 1'b0;
  endtask
  task want(input [3:0] k, input [6:0] d, input c, input p);
    for (int i = 0; i < 40 && tx_cnt == n0; i++) @(negedge clk);
    chk("txn", tx_cnt, n0 + 1);
    chk("kind", l_kind, k);
    chk("dst", l_dst, d);
    chk("cmd", l_cmd, c);
    chk("pf", l_pf, p);
  endtask
  task quiet;
    repeat (12) @(negedge clk);
    chk("txn", tx_cnt, n0);
  endtask
  // Request until taken or refused; user never sees a stale pulse
  task send(input [6:0] d, input t2, input blk);
    n0 = tx_cnt;
    {usr_dst, usr_t2, usr_req} = {d, t2, 1'b1};
    for (int i = 0; i < 40 && !usr_ack_ff && !usr_blk_ff; i++) @(negedge clk);
    usr_req = 1'b0;
    chk("blk", usr_blk_ff, blk);
    chk("ack", usr_ack_ff, !blk);
    if (!blk) want(t2 ? `LPC_K_I : `LPC_K_UI, d, 1'b1, 1'b0);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_busy;
    send(7'h05, 1'b0, 1'b0);
    rx(`LPC_K_URNR, 8'h05, 1'b0);
    repeat (4) @(negedge clk);
    send(7'h05, 1'b0, 1'b1);
    send(7'h06, 1'b0, 1'b0);
    rx(`LPC_K_URR, 8'h85, 1'b0);
    repeat (4) @(negedge clk);
    send(7'h05, 1'b0, 1'b0);
  endtask
  task t_rx_ui;
    rx_dst_kind = `LPC_A_GLOBAL;
    rx(`LPC_K_UI, 8'h03, 1'b0);
    quiet;
    chk("dat", dat_cnt, 1);
    rx_dst_kind = `LPC_A_INDIV;
    rx_local_busy = 1'b1;
    rx(`LPC_K_UI, 8'h03, 1'b0);
    want(`LPC_K_URNR, 7'h03, 1'b0, 1'b1);
    rx_local_busy = 1'b0;
  endtask
  task t_test;
    rx_err = 1'b1;
    rx(`LPC_K_TEST, 8'h04, 1'b1);
    rx_err = 1'b0;
    quiet;
    chk("evt", evt_cnt, 1);
    test_fail = 1'b1;
    @(negedge clk);
    test_fail = 1'b0;
    repeat (4) @(negedge clk);
    chk("evt", evt_cnt, 2);
    rx(`LPC_K_TEST, 8'h04, 1'b1);
    want(`LPC_K_TEST, 7'h04, 1'b0, 1'b1);
  endtask
  task t_modes;
    send(7'h05, 1'b1, 1'b1);
    rx(`LPC_K_I, 8'h05, 1'b0);
    want(`LPC_K_DM, 7'h05, 1'b0, 1'b0);
    chk("dat", dat_cnt, 1);
    rx(`LPC_K_S, 8'h05, 1'b0);
    want(`LPC_K_DM, 7'h05, 1'b0, 1'b0);
    rx(`LPC_K_S, 8'h85, 1'b0);
    want(`LPC_K_DM, 7'h05, 1'b0, 1'b0);
    rx_src_kind = `LPC_A_GROUP;
    rx(`LPC_K_DISC, 8'h05, 1'b1);
    quiet;
    rx_src_kind = `LPC_A_INDIV;
    rx(`LPC_K_DISC, 8'h05, 1'b1);
    want(`LPC_K_DM, 7'h05, 1'b0, 1'b1);
    rx(`LPC_K_SABME, 8'h05, 1'b1);
    repeat (20) @(negedge clk);
    chk("mode", mode_ff, `LPC_M_ABM);
    send(7'h05, 1'b1, 1'b0);
    rx(`LPC_K_I, 8'h05, 1'b0);
    repeat (20) @(negedge clk);
    chk("dat", dat_cnt, 2);
    rx(`LPC_K_DISC, 8'h05, 1'b1);
    want(`LPC_K_UA, 7'h05, 1'b0, 1'b1);
    repeat (4) @(negedge clk);
    chk("mode", mode_ff, `LPC_M_ADM);
    rx(`LPC_K_SABME, 8'h05, 1'b1);
    repeat (20) @(negedge clk);
    force_adm = 1'b1;
    repeat (4) @(negedge clk);
    chk("mode", mode_ff, `LPC_M_ADM);
    force_adm = 1'b0;
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence: reset five cycles, then slow framer throughout
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    dly = 4'h3;
    @(negedge clk);
    t_busy;
    t_rx_ui;
    t_test;
    t_modes;
    final_report;
  end
endmodule // link_procedure_control_test
`default_nettype wire
